// [design/ilw_top.sv]
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "ilw_params.svh"

module ilw_top
#(
  parameter int unsigned OSC_DIV = `ILW_OSC_DIV
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        software_start_option,
  input  wire logic        watchdog_reset_enable,
  input  wire logic        debug_halt_stop,
  input  wire logic        core_halted,
  input  wire logic        lowpower_mode,
  output logic             watchdog_reset_out,
  output logic             low_speed_osc_enable
);

  logic                 ap_valid;
  logic                 wr_q;
  logic [11:0]          waddr_q;
  logic [31:0]          hrdata_q;
  logic [31:0]          rd_d;
  logic                 ready_q;
  logic                 resp_q;
  logic [15:0]          key;
  logic                 wr_key;
  logic                 wr_pd;
  logic                 wr_rel;
  logic                 wr_frz;
  logic                 feed;
  logic                 start;
  logic                 expire;
  logic                 run_en;
  logic                 unlock_q;
  logic                 pvu_q;
  logic                 reload_update_busy_q;
  logic [1:0]           pvu_cnt_q;
  logic [1:0]           reload_update_busy_cnt_q;
  ilw_pkg::ilw_pd_t     pd_q;
  ilw_pkg::ilw_pd_t     pd_stage_q;
  ilw_pkg::ilw_cnt_t    rel_q;
  ilw_pkg::ilw_cnt_t    rel_stage_q;
  ilw_pkg::ilw_cnt_t    cnt_q;
  ilw_pkg::ilw_run_e    st_q;
  logic                 run_hold_q;
  logic                 lp_arm_q;
  logic                 boot_q;
  logic                 rst_out_q;
  logic                 osc_en_q;
  logic                 osc_tick;
  logic                 cnt_tick;

  assign hrdata               = hrdata_q;
  assign hreadyout            = ready_q;
  assign hresp                = resp_q;
  assign watchdog_reset_out   = rst_out_q;
  assign low_speed_osc_enable = osc_en_q;

  // Zero wait states: every access completes in its first data phase
  assign ap_valid = hsel && htrans[1] && hready;
  assign key      = hwdata[15:0];
  assign wr_key   = wr_q && (waddr_q == `ILW_OFF_KEY);
  assign wr_frz   = wr_q && (waddr_q == `ILW_OFF_HOLD);
  assign wr_pd    = wr_q && (waddr_q == `ILW_OFF_PREDIV)
                    && unlock_q && !pvu_q;
  assign wr_rel   = wr_q && (waddr_q == `ILW_OFF_RELOAD)
                    && unlock_q && !reload_update_busy_q;
  assign feed     = wr_key && (key == ilw_pkg::ILW_KEY_FEED);
  assign start    = wr_key && (key == ilw_pkg::ILW_KEY_START);

  // Any active freeze source stops both counter and prescaler
  assign run_en = (st_q == ilw_pkg::ST_RUNNING)
                  && !run_hold_q
                  && !(lp_arm_q && lowpower_mode)
                  && !(core_halted && debug_halt_stop);

  // A feed in the same cycle as the final tick rescues the system
  assign expire = (st_q == ilw_pkg::ST_RUNNING) && run_en && cnt_tick
                  && (cnt_q == 12'h000) && watchdog_reset_enable
                  && !feed;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_q     <= 1'b0;
      waddr_q  <= 12'h000;
      hrdata_q <= 32'h0000_0000;
      ready_q  <= 1'b1;
      resp_q   <= 1'b0;
    end
    else
    begin
      wr_q     <= ap_valid && hwrite && (hsize == `ILW_HSIZE_WORD);
      waddr_q  <= haddr;
      hrdata_q <= rd_d;
      ready_q  <= 1'b1;
      resp_q   <= 1'b0;
    end
  end

  // Key and hold registers are write-only and read as zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (ap_valid && !hwrite)
    begin
      case (haddr)
        `ILW_OFF_PREDIV: rd_d = 32'(pd_q);
        `ILW_OFF_RELOAD: rd_d = 32'(rel_q);
        `ILW_OFF_STATUS:
        begin
          rd_d[`ILW_STS_PVU]  = pvu_q;
          rd_d[`ILW_STS_RELOAD_UPDATE_BUSY] = reload_update_busy_q;
          rd_d[`ILW_STS_RUNH] = run_hold_q;
          rd_d[`ILW_STS_LPH]  = lp_arm_q;
        end
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      unlock_q <= 1'b0;
    else if (wr_key)
      unlock_q <= (key == ilw_pkg::ILW_KEY_UNLOCK);
  end

  // Staged value lands in the counting domain after two oscillator ticks
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pvu_q      <= 1'b0;
      pvu_cnt_q  <= 2'h0;
      pd_stage_q <= `ILW_PD_RST;
      pd_q       <= `ILW_PD_RST;
    end
    else if (wr_pd)
    begin
      pd_stage_q <= hwdata[2:0];
      pvu_q      <= 1'b1;
      pvu_cnt_q  <= 2'h0;
    end
    else if (pvu_q && osc_tick)
    begin
      if (pvu_cnt_q == `ILW_SYNC_TICKS - 2'h1)
      begin
        pd_q  <= pd_stage_q;
        pvu_q <= 1'b0;
      end
      else
        pvu_cnt_q <= pvu_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reload_update_busy_q      <= 1'b0;
      reload_update_busy_cnt_q  <= 2'h0;
      rel_stage_q <= `ILW_RELOAD_RST;
      rel_q       <= `ILW_RELOAD_RST;
    end
    else if (wr_rel)
    begin
      rel_stage_q <= hwdata[11:0];
      reload_update_busy_q      <= 1'b1;
      reload_update_busy_cnt_q  <= 2'h0;
    end
    else if (reload_update_busy_q && osc_tick)
    begin
      if (reload_update_busy_cnt_q == `ILW_SYNC_TICKS - 2'h1)
      begin
        rel_q  <= rel_stage_q;
        reload_update_busy_q <= 1'b0;
      end
      else
        reload_update_busy_cnt_q <= reload_update_busy_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      run_hold_q <= 1'b0;
    else if (wr_key && (key == ilw_pkg::ILW_KEY_HOLD))
      run_hold_q <= 1'b1;
    else if (wr_key && (key == ilw_pkg::ILW_KEY_RESUME))
      run_hold_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      lp_arm_q <= 1'b0;
    else if (wr_frz && (key == ilw_pkg::ILW_KEY_LPTOGGLE))
      lp_arm_q <= !lp_arm_q;
  end

  // Start option is sampled on the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_q   <= ilw_pkg::ST_STOPPED;
      boot_q <= 1'b1;
    end
    else
    begin
      boot_q <= 1'b0;
      unique case (st_q)
        ilw_pkg::ST_STOPPED:
          if (start || (boot_q && !software_start_option))
            st_q <= ilw_pkg::ST_RUNNING;
        ilw_pkg::ST_RUNNING:
          if (expire)
            st_q <= ilw_pkg::ST_EXPIRED;
        ilw_pkg::ST_EXPIRED: st_q <= ilw_pkg::ST_EXPIRED;
        default: st_q <= ilw_pkg::ST_STOPPED;
      endcase
    end
  end

  // Wrap from zero to 0xFFF keeps counting when reset is disabled
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_q <= `ILW_RELOAD_RST;
    else if (feed)
      cnt_q <= rel_q;
    else if (run_en && cnt_tick)
      cnt_q <= cnt_q - 12'h001;
  end

  // Reset request stays up until the system reset clears it
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rst_out_q <= 1'b0;
      osc_en_q  <= 1'b0;
    end
    else
    begin
      if (expire)
        rst_out_q <= 1'b1;
      osc_en_q <= (st_q != ilw_pkg::ST_STOPPED);
    end
  end

  ilw_tick
  #(
    .OSC_DIV (OSC_DIV)
  )
  u_tick
  (
    .clk      (clk),
    .reset    (reset),
    .run      (run_en),
    .pd       (pd_q),
    .osc_tick (osc_tick),
    .cnt_tick (cnt_tick)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  localparam int unsigned BUSY_LIMIT = OSC_DIV * 3;
  int unsigned pvu_age_q;

  always_ff @(posedge clk)
  begin
    if (reset || !pvu_q)
      pvu_age_q <= 0;
    else
      pvu_age_q <= pvu_age_q + 1;
  end

  sequence s_pd_accept;
    wr_q && (waddr_q == `ILW_OFF_PREDIV) && unlock_q && !pvu_q;
  endsequence
  sequence s_pd_busy;
    pvu_q && $stable(pd_q);
  endsequence
  property p_pd_busy;
    s_pd_accept |=> s_pd_busy;
  endproperty
  a_pd_busy: assert property (p_pd_busy)
    else $error("prescale busy not raised on accepted write");
  property p_pd_done;
    pvu_age_q <= BUSY_LIMIT;
  endproperty
  a_pd_done: assert property (p_pd_done)
    else $error("prescale busy never cleared");
  property p_locked;
    (wr_q && (waddr_q == `ILW_OFF_RELOAD) && !unlock_q && !reload_update_busy_q)
      |=> !reload_update_busy_q && $stable(rel_stage_q);
  endproperty
  a_locked: assert property (p_locked)
    else $error("protected reload write was taken");
  property p_relock;
    (wr_key && (key != ilw_pkg::ILW_KEY_UNLOCK)) |=> !unlock_q;
  endproperty
  a_relock: assert property (p_relock)
    else $error("protection not restored by key write");
  property p_start;
    (start && (st_q == ilw_pkg::ST_STOPPED))
      |=> (st_q == ilw_pkg::ST_RUNNING) ##1 low_speed_osc_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("start key did not start the counter");
  property p_feed;
    feed |=> (cnt_q == $past(rel_q)) && !unlock_q;
  endproperty
  a_feed: assert property (p_feed)
    else $error("feed did not reload counter");
  property p_expire;
    expire |=> watchdog_reset_out && (st_q == ilw_pkg::ST_EXPIRED);
  endproperty
  a_expire: assert property (p_expire)
    else $error("zero count did not raise reset");
  property p_no_reset;
    ((st_q == ilw_pkg::ST_RUNNING) && run_en && cnt_tick
      && (cnt_q == 12'h000) && !watchdog_reset_enable && !feed)
      |=> (cnt_q == 12'hFFF) && !watchdog_reset_out;
  endproperty
  a_no_reset: assert property (p_no_reset)
    else $error("reset raised while disabled");
  property p_frozen;
    (!run_en && !feed) |=> $stable(cnt_q);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("counter moved while frozen");
  property p_decrement;
    (run_en && cnt_tick && !feed && (cnt_q != 12'h000))
      |=> (cnt_q == $past(cnt_q) - 12'h001);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step down on tick");
  property p_hw_start;
    (boot_q && !software_start_option) |=> (st_q == ilw_pkg::ST_RUNNING);
  endproperty
  a_hw_start: assert property (p_hw_start)
    else $error("hardware start did not run the counter");
  property p_lp_toggle;
    (wr_frz && (key == ilw_pkg::ILW_KEY_LPTOGGLE))
      |=> (lp_arm_q != $past(lp_arm_q));
  endproperty
  a_lp_toggle: assert property (p_lp_toggle)
    else $error("low-power hold code did not toggle");

endmodule

// [design/ilw_params.svh]
`ifndef ILW_PARAMS_SVH
`define ILW_PARAMS_SVH
// Notes on behaviour
// - Twelve-bit down-counter ticks on prescaled oscillator.
// - Start key begins the countdown.
// - Count reaching zero raises watchdog reset.
// - Feed key reloads counter from reload field.
// - First run from 0xFFF, later from reload.
// - Hardware start option runs watchdog after reset.
// - Prescaler and reload writes need unlock key.
// - Any other key restores write protection.
// - Feed also restores write protection.
// - Busy flags cover each value transfer.
// - Readback invalid while its busy flag set.
// - Pending writes finish without software waiting.
// - Prescaler code picks divide by 4 to 256.
// - Timeout is divider times reload plus one.
// - Reset only when reset enable is set.
// - Debug halt stops counter when stop bit set.
// - Once started, only reset or freeze stops.
// - Hold key freezes, resume key unfreezes.
// - Low-power hold code toggles sleep freezing.
// - Running watchdog forces oscillator on.
// - Status shows run and low-power hold flags.

`define ILW_OFF_KEY    12'h000
`define ILW_OFF_PREDIV 12'h004
`define ILW_OFF_RELOAD 12'h008
`define ILW_OFF_STATUS 12'h00C
`define ILW_OFF_HOLD   12'h010

`define ILW_STS_PVU    0
`define ILW_STS_RELOAD_UPDATE_BUSY   1
`define ILW_STS_RUNH   2
`define ILW_STS_LPH    3

`define ILW_PD_RST     3'h0
`define ILW_RELOAD_RST 12'hFFF
`define ILW_HSIZE_WORD 3'h2

`define ILW_CLK_HZ     250_000_000
`define ILW_OSC_HZ     32_000
`define ILW_OSC_DIV    (`ILW_CLK_HZ / `ILW_OSC_HZ)
`define ILW_SYNC_TICKS 2'h2

`endif

// [design/ilw_pkg.sv]
package ilw_pkg;

  typedef enum logic [15:0]
  {
    ILW_KEY_FEED     = 16'hAAAA,
    ILW_KEY_START    = 16'hCCCC,
    ILW_KEY_UNLOCK   = 16'h5555,
    ILW_KEY_HOLD     = 16'h4567,
    ILW_KEY_RESUME   = 16'h89AB,
    ILW_KEY_LPTOGGLE = 16'hDDDD
  } ilw_key_e;

  typedef enum logic [1:0]
  {
    ST_STOPPED = 2'h0,
    ST_RUNNING = 2'h1,
    ST_EXPIRED = 2'h3
  } ilw_run_e;

  typedef logic [2:0]  ilw_pd_t;
  typedef logic [11:0] ilw_cnt_t;

endpackage

// [design/ilw_tick.sv]
`timescale 1ns/1ps
`include "ilw_params.svh"

module ilw_tick
#(
  parameter int unsigned OSC_DIV = `ILW_OSC_DIV
)
(
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic           run,
  input  wire ilw_pkg::ilw_pd_t pd,
  output logic                osc_tick,
  output logic                cnt_tick
);

  logic [15:0] osc_cnt_q;
  logic [7:0]  pre_q;
  logic [7:0]  lim;

  // Oscillator keeps running so pending updates finish in low power
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      osc_cnt_q <= 16'h0000;
      osc_tick  <= 1'b0;
    end
    else
    begin
      osc_tick  <= (osc_cnt_q == 16'(OSC_DIV - 1));
      osc_cnt_q <= (osc_cnt_q == 16'(OSC_DIV - 1)) ? 16'h0000
                                                  : osc_cnt_q + 16'h0001;
    end
  end

  // Codes 110 and 111 both give the longest divider
  assign lim = (pd[2:1] == 2'h3) ? 8'hFF
                                 : 8'((9'h004 << pd) - 9'h001);

  // Prescaler holds its phase while frozen
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre_q    <= 8'h00;
      cnt_tick <= 1'b0;
    end
    else
    begin
      cnt_tick <= run && osc_tick && (pre_q == lim);
      if (run && osc_tick)
      begin
        pre_q <= (pre_q == lim) ? 8'h00 : pre_q + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_tick_div;
    (run && osc_tick && (pre_q == lim)) |=> (cnt_tick && (pre_q == 8'h00));
  endproperty
  a_tick_div: assert property (p_tick_div)
    else $error("prescaler did not wrap at its divider");

  property p_tick_src;
    cnt_tick |-> $past(osc_tick) && $past(run);
  endproperty
  a_tick_src: assert property (p_tick_src)
    else $error("count tick without oscillator tick");

endmodule

// [tb/ilw_top_test.sv]
`timescale 1ns/1ps
`include "ilw_params.svh"

module ilw_top_test;
  // Short oscillator divide keeps the full 0xFFF run near 65k clocks
  localparam int O = 4;
  logic        clk;
  logic        reset;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sw_opt;
  logic        rst_en;
  logic        dbg_stop;
  logic        halted;
  logic        lp_mode;
  logic        wd_out;
  logic        osc_en;
  logic [31:0] rd;
  int          num_errors;
  int          num_checks;

  ilw_top #(.OSC_DIV(O)) ilw_top_i
  (
    .clk                   (clk),
    .reset                 (reset),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (hsize),
    .hwdata                (hwdata),
    .hready                (hreadyout),
    .hrdata                (hrdata),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .software_start_option (sw_opt),
    .watchdog_reset_enable (rst_en),
    .debug_halt_stop       (dbg_stop),
    .core_halted           (halted),
    .lowpower_mode         (lp_mode),
    .watchdog_reset_out    (wd_out),
    .low_speed_osc_enable  (osc_en)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Read data is taken at the data phase edge, before the slave updates
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rdr(input logic [11:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic key(input logic [15:0] k);
    bus(1'b1, `ILW_OFF_KEY, {16'h0000, k});
  endtask

  task automatic do_reset;
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      rdr(`ILW_OFF_STATUS);
      n++;
    end
    while (rd[1:0] !== 2'b00 && n < 40);
    chk1("busy_clear", 1'b1, rd[1:0] === 2'b00);
  endtask

  task automatic setup(input logic [2:0] pd, input logic [11:0] reload_value_field);
    do_reset;
    key(ilw_pkg::ILW_KEY_UNLOCK);
    bus(1'b1, `ILW_OFF_PREDIV, {29'h0000_0000, pd});
    bus(1'b1, `ILW_OFF_RELOAD, {20'h0_0000, reload_value_field});
    wait_idle;
    key(ilw_pkg::ILW_KEY_FEED);
    key(ilw_pkg::ILW_KEY_START);
  endtask

  // Lower bound allows for a partial first prescaler period
  task automatic wait_exp(input int lo, input int hi);
    int n;
    n = 0;
    while (wd_out !== 1'b1 && n < hi)
    begin
      @(posedge clk);
      n++;
    end
    chk1("reset_out", 1'b1, wd_out);
    chk1("not_early", 1'b1, n >= lo);
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
    chk1("reset_low", 1'b0, wd_out);
  endtask

  task automatic t_reset;
    do_reset;
    chk1("osc_en", 1'b0, osc_en);
    chk1("hresp", 1'b0, hresp);
    chk1("hready", 1'b1, hreadyout);
    rdr(`ILW_OFF_STATUS);
    chk32("status", 32'h0000_0000, rd);
    rdr(`ILW_OFF_PREDIV);
    chk32("prediv", 32'h0000_0000, rd);
    rdr(`ILW_OFF_RELOAD);
    chk32("reload", 32'h0000_0FFF, rd);
    rdr(`ILW_OFF_KEY);
    chk32("key", 32'h0000_0000, rd);
    rdr(12'h020);
    chk32("unmapped", 32'h0000_0000, rd);
    quiet(200);
  endtask

  task automatic t_protect;
    do_reset;
    bus(1'b1, `ILW_OFF_RELOAD, 32'h0000_0010);
    rdr(`ILW_OFF_RELOAD);
    chk32("reload_locked", 32'h0000_0FFF, rd);
    key(ilw_pkg::ILW_KEY_UNLOCK);
    bus(1'b1, `ILW_OFF_RELOAD, 32'h0000_0005);
    rdr(`ILW_OFF_STATUS);
    chk32("reload_busy", 32'h0000_0002, rd);
    rdr(`ILW_OFF_RELOAD);
    chk32("reload_old", 32'h0000_0FFF, rd);
    wait_idle;
    rdr(`ILW_OFF_RELOAD);
    chk32("reload_new", 32'h0000_0005, rd);
    key(16'h1234);
    bus(1'b1, `ILW_OFF_RELOAD, 32'h0000_0007);
    wait_idle;
    rdr(`ILW_OFF_RELOAD);
    chk32("reload_relock", 32'h0000_0005, rd);
    key(ilw_pkg::ILW_KEY_UNLOCK);
    key(ilw_pkg::ILW_KEY_FEED);
    bus(1'b1, `ILW_OFF_RELOAD, 32'h0000_0007);
    wait_idle;
    rdr(`ILW_OFF_RELOAD);
    chk32("reload_fedlock", 32'h0000_0005, rd);
    key(ilw_pkg::ILW_KEY_UNLOCK);
    bus(1'b1, `ILW_OFF_PREDIV, 32'h0000_0003);
    rdr(`ILW_OFF_STATUS);
    chk32("prediv_busy", 32'h0000_0001, rd);
    rdr(`ILW_OFF_PREDIV);
    chk32("prediv_old", 32'h0000_0000, rd);
    wait_idle;
    rdr(`ILW_OFF_PREDIV);
    chk32("prediv_new", 32'h0000_0003, rd);
  endtask

  task automatic t_divider;
    int d;
    for (int c = 0; c < 8; c++)
    begin
      setup(c[2:0], 12'h001);
      d = (c >= 6) ? 256 : (4 << c);
      wait_exp(d * O - 2, 2 * d * O + 8);
      chk1("osc_en", 1'b1, osc_en);
    end
  endtask

  task automatic t_feed;
    setup(3'h0, 12'h003);
    repeat (6)
    begin
      repeat (30) @(posedge clk);
      key(ilw_pkg::ILW_KEY_FEED);
      chk1("fed", 1'b0, wd_out);
    end
    wait_exp(46, 72);
  endtask

  task automatic t_noreset;
    rst_en <= 1'b0;
    setup(3'h0, 12'h001);
    quiet(200);
    rst_en <= 1'b1;
  endtask

  task automatic t_freeze;
    setup(3'h0, 12'h002);
    key(ilw_pkg::ILW_KEY_HOLD);
    rdr(`ILW_OFF_STATUS);
    chk32("run_hold", 32'h0000_0004, rd);
    quiet(300);
    key(ilw_pkg::ILW_KEY_RESUME);
    wait_exp(0, 56);
  endtask

  task automatic t_lowpower;
    setup(3'h0, 12'h002);
    bus(1'b1, `ILW_OFF_HOLD, 32'h0000_DDDD);
    rdr(`ILW_OFF_STATUS);
    chk32("lp_armed", 32'h0000_0008, rd);
    lp_mode <= 1'b1;
    quiet(300);
    bus(1'b1, `ILW_OFF_HOLD, 32'h0000_DDDD);
    rdr(`ILW_OFF_STATUS);
    chk32("lp_disarmed", 32'h0000_0000, rd);
    wait_exp(0, 56);
    lp_mode <= 1'b0;
  endtask

  task automatic t_debug;
    setup(3'h0, 12'h002);
    halted <= 1'b1;
    dbg_stop <= 1'b1;
    quiet(300);
    dbg_stop <= 1'b0;
    wait_exp(0, 56);
    halted <= 1'b0;
  endtask

  task automatic t_hwstart;
    sw_opt <= 1'b0;
    do_reset;
    sw_opt <= 1'b1;
    wait_exp(4095 * 16 - 4, 4096 * 16 + 8);
    chk1("osc_en", 1'b1, osc_en);
  endtask

  initial
  begin
    num_errors = 0;
    num_checks = 0;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    sw_opt = 1'b1;
    rst_en = 1'b1;
    dbg_stop = 1'b0;
    halted = 1'b0;
    lp_mode = 1'b0;
    t_reset;
    t_protect;
    t_divider;
    t_feed;
    t_noreset;
    t_freeze;
    t_lowpower;
    t_debug;
    t_hwstart;
    summarize;
  end

  initial
  begin
    repeat (95000) @(posedge clk);
    num_errors++;
    summarize;
  end
endmodule
